// ---- common/avbpt_pkg.sv ----
// Package: constants for the time-of-day and precise-time stream port
package avbpt_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned NS_PER_SEC = 1_000_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_NS = TICK_MS * 1_000_000;
  localparam int unsigned CYCLE_US = 125;
  localparam int unsigned CYCLE_NS = CYCLE_US * 1_000;
  localparam int unsigned HALF_CYCLE_NS = CYCLE_NS / 2;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned ISO_HALF_CYCLES = HALF_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned LINK_DIV = 2;
  localparam int unsigned NS_W = 32;
  localparam int unsigned SEC_W = 48;
  localparam int unsigned BYTE_W = 8;
  localparam logic [NS_W-1:0] NS_STEP = NS_W'(CLK_PERIOD_NS);
  localparam logic [NS_W-1:0] NS_WRAP = NS_W'(NS_PER_SEC);
  localparam logic [SEC_W-1:0] SEC_ONE = 48'h0000_0000_0001;
  localparam logic RX_USER_GOOD = 1'b0;
  localparam logic RX_USER_BAD = 1'b1;
  typedef enum logic [1:0] {AVBPT_IDLE, AVBPT_PENDING, AVBPT_SENT} avbpt_ptp_e;
endpackage : avbpt_pkg

// ---- verilog/avbpt_port.sv ----
// Module: real-time clock, isochronous clock, precise-time events and byte streams
// Operation
// R01 - Pulse the timer interrupt once per 10 ms measured by the real-time clock.
// R02 - Raise transmit timestamp interrupt after a precise-time packet leaves transmit buffers.
// R03 - Raise receive timestamp interrupt after a precise-time packet leaves receive buffers.
// R04 - Output the clock's nanoseconds as a synchronized 32-bit field.
// R05 - Output the clock's whole seconds as a synchronized 48-bit field.
// R06 - Drive an 8 kHz clock locked to the real-time clock, 125 us period.
// R07 - Receive user bit: low means frame good, high means bad.
// R08 - Transmit stream is a byte with valid, ready, last, user on driven clock.
// R09 - Receive host takes a byte every valid cycle; no backpressure possible.
`timescale 1ns/1ps
module avbpt_port
  import avbpt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Stream clocks and resets
  output logic tx_clk_o,
  output logic rx_clk_o,
  input wire logic tx_rst_n_i,
  input wire logic rx_rst_n_i,
  // Transmit stream from host
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic tx_last_i,
  input wire logic [BYTE_W-1:0] tx_data_i,
  input wire logic tx_user_i,
  // Frames from the receive path
  input wire logic rxin_valid_i,
  input wire logic rxin_last_i,
  input wire logic [BYTE_W-1:0] rxin_data_i,
  input wire logic rxin_bad_i,
  input wire logic rxin_ptp_i,
  // Receive stream to host
  output logic rx_valid_o,
  output logic rx_last_o,
  output logic [BYTE_W-1:0] rx_data_o,
  output logic rx_user_o,
  // Transmit path: byte handed to the line, precise-time marker
  output logic txout_valid_o,
  output logic [BYTE_W-1:0] txout_data_o,
  output logic txout_last_o,
  input wire logic txout_ptp_sent_i,
  // Time of day and events
  output logic [NS_W-1:0] rtc_ns_o,
  output logic [SEC_W-1:0] rtc_sec_o,
  output logic isochronous_cycle_clock_o,
  output logic ptp_timer_irq_o,
  output logic ptp_tx_irq_o,
  output logic ptp_rx_irq_o
);
  logic [NS_W-1:0] ns_reg;
  logic [SEC_W-1:0] sec_reg;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
  logic [$clog2(ISO_HALF_CYCLES)-1:0] iso_cnt_reg;
  logic [$clog2(LINK_DIV)-1:0] div_reg;
  logic link_en;
  logic tx_rst_s1_reg, tx_rst_s2_reg, rx_rst_s1_reg, rx_rst_s2_reg;
  logic ptp_s1_reg, ptp_s2_reg, ptp_s3_reg;
  avbpt_ptp_e rx_ptp_reg;

  // Time of day advances one clock period per cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ns_reg <= '0;
      sec_reg <= '0;
    end else if (ns_reg + NS_STEP >= NS_WRAP) begin
      ns_reg <= ns_reg + NS_STEP - NS_WRAP;
      sec_reg <= sec_reg + SEC_ONE;
    end else begin
      ns_reg <= ns_reg + NS_STEP;
    end
  end

  // Registered copies keep both fields coherent for the outside logic
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rtc_ns_o <= '0;
      rtc_sec_o <= '0;
    end else begin
      rtc_ns_o <= ns_reg; // R04
      rtc_sec_o <= sec_reg; // R05
    end
  end

  // Periodic tick
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tick_cnt_reg <= '0;
      ptp_timer_irq_o <= 1'b0;
    end else if (tick_cnt_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      ptp_timer_irq_o <= 1'b1; // R01
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      ptp_timer_irq_o <= 1'b0;
    end
  end

  // Isochronous clock toggles every half cycle of the same time base
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      iso_cnt_reg <= '0;
      isochronous_cycle_clock_o <= 1'b0;
    end else if (iso_cnt_reg == ($clog2(ISO_HALF_CYCLES))'(ISO_HALF_CYCLES - 1)) begin
      iso_cnt_reg <= '0;
      isochronous_cycle_clock_o <= ~isochronous_cycle_clock_o; // R06
    end else begin
      iso_cnt_reg <= iso_cnt_reg + 1'b1;
    end
  end

  // Stream clocks: divided from mclk; transmit data moves on the enable before the rising edge, receive data moves every mclk cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_reg <= '0;
      tx_clk_o <= 1'b0;
      rx_clk_o <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      tx_clk_o <= div_reg[0]; // R08
      rx_clk_o <= div_reg[0];
    end
  end
  assign link_en = (div_reg == '0);

  // Stream resets arrive from outside and are synchronised
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_rst_s1_reg <= 1'b0;
      tx_rst_s2_reg <= 1'b0;
      rx_rst_s1_reg <= 1'b0;
      rx_rst_s2_reg <= 1'b0;
    end else begin
      tx_rst_s1_reg <= tx_rst_n_i;
      tx_rst_s2_reg <= tx_rst_s1_reg;
      rx_rst_s1_reg <= rx_rst_n_i;
      rx_rst_s2_reg <= rx_rst_s1_reg;
    end
  end

  // Transmit stream: host bytes taken on the link enable while ready
  always_ff @(posedge mclk_i) begin
    if (srst_i || !tx_rst_s2_reg) begin
      tx_ready_o <= 1'b0;
      txout_valid_o <= 1'b0;
      txout_data_o <= '0;
      txout_last_o <= 1'b0;
    end else if (link_en) begin
      tx_ready_o <= 1'b1; // R08
      txout_valid_o <= tx_valid_i && tx_ready_o;
      txout_data_o <= tx_data_i;
      txout_last_o <= tx_last_i && tx_valid_i && tx_ready_o;
    end else begin
      txout_valid_o <= 1'b0;
    end
  end

  // Receive stream: no ready, host must take each valid byte
  always_ff @(posedge mclk_i) begin
    if (srst_i || !rx_rst_s2_reg) begin
      rx_valid_o <= 1'b0;
      rx_last_o <= 1'b0;
      rx_data_o <= '0;
      rx_user_o <= RX_USER_GOOD;
    end else begin
      rx_valid_o <= rxin_valid_i; // R09
      rx_last_o <= rxin_valid_i && rxin_last_i;
      rx_data_o <= rxin_data_i;
      rx_user_o <= (rxin_valid_i && rxin_last_i && rxin_bad_i) ? RX_USER_BAD : RX_USER_GOOD; // R07
    end
  end

  // Transmit marker comes from the line side domain; edge found after sync
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ptp_s1_reg <= 1'b0;
      ptp_s2_reg <= 1'b0;
      ptp_s3_reg <= 1'b0;
      ptp_tx_irq_o <= 1'b0;
    end else begin
      ptp_s1_reg <= txout_ptp_sent_i;
      ptp_s2_reg <= ptp_s1_reg;
      ptp_s3_reg <= ptp_s2_reg;
      ptp_tx_irq_o <= ptp_s2_reg && !ptp_s3_reg; // R02
    end
  end

  // Receive event fires once the last byte of a precise-time frame has gone out
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_ptp_reg <= AVBPT_IDLE;
      ptp_rx_irq_o <= 1'b0;
    end else begin
      ptp_rx_irq_o <= 1'b0;
      case (rx_ptp_reg)
        AVBPT_IDLE: begin
          if (rxin_valid_i && rxin_last_i && rxin_ptp_i) begin
            rx_ptp_reg <= AVBPT_PENDING;
          end
        end
        AVBPT_PENDING: begin
          rx_ptp_reg <= AVBPT_SENT;
          ptp_rx_irq_o <= 1'b1; // R03
        end
        AVBPT_SENT: begin
          rx_ptp_reg <= AVBPT_IDLE;
        end
        default: begin
          rx_ptp_reg <= AVBPT_IDLE;
        end
      endcase
    end
  end

  sequence s_rx_ptp_last;
    rxin_valid_i && rxin_last_i && rxin_ptp_i && rx_ptp_reg == AVBPT_IDLE;
  endsequence
  sequence s_rx_irq_pulse;
    ##1 rx_last_o ##1 ptp_rx_irq_o ##1 !ptp_rx_irq_o;
  endsequence

  AST_TIMER_GAP: assert property (@(posedge mclk_i) disable iff (srst_i) // R01
    $rose(ptp_timer_irq_o) |=> !ptp_timer_irq_o [*8]) else $error("timer pulse too long or too frequent");
  AST_TIMER_CNT: assert property (@(posedge mclk_i) disable iff (srst_i) // R01
    ptp_timer_irq_o |-> $past(tick_cnt_reg) == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) else $error("tick early");
  AST_TX_IRQ: assert property (@(posedge mclk_i) disable iff (srst_i) // R02
    $rose(ptp_s2_reg) |=> ptp_tx_irq_o ##1 !ptp_tx_irq_o) else $error("tx timestamp event missing");
  AST_RX_IRQ: assert property (@(posedge mclk_i) disable iff (srst_i) // R03
    s_rx_ptp_last |-> s_rx_irq_pulse) else $error("rx timestamp event missing");
  AST_NS_FIELD: assert property (@(posedge mclk_i) disable iff (srst_i) // R04
    rtc_ns_o < NS_WRAP && (rtc_ns_o == $past(ns_reg))) else $error("nanoseconds field wrong");
  // A carry shows as the nanoseconds field stepping backwards between two cycles
  AST_SEC_FIELD: assert property (@(posedge mclk_i) disable iff (srst_i) // R05
    $past(rtc_ns_o) > rtc_ns_o |-> rtc_sec_o == $past(rtc_sec_o) + SEC_ONE) else $error("seconds not carried");
  AST_SEC_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i) // R05
    $past(rtc_ns_o) <= rtc_ns_o |-> $stable(rtc_sec_o)) else $error("seconds moved without carry");
  AST_ISO_CLK: assert property (@(posedge mclk_i) disable iff (srst_i) // R06
    $changed(isochronous_cycle_clock_o) |-> $past(iso_cnt_reg) == ($clog2(ISO_HALF_CYCLES))'(ISO_HALF_CYCLES - 1))
    else $error("isochronous clock phase wrong");
  AST_RX_USER: assert property (@(posedge mclk_i) disable iff (srst_i || !rx_rst_s2_reg) // R07
    rxin_valid_i && rxin_last_i |=> rx_user_o == $past(rxin_bad_i)) else $error("frame status wrong");
  AST_TX_TAKE: assert property (@(posedge mclk_i) disable iff (srst_i || !tx_rst_s2_reg) // R08
    link_en && tx_valid_i && tx_ready_o |=> txout_valid_o && txout_data_o == $past(tx_data_i))
    else $error("tx byte lost");
  AST_RX_PASS: assert property (@(posedge mclk_i) disable iff (srst_i || !rx_rst_s2_reg) // R09
    rxin_valid_i |=> rx_valid_o && rx_data_o == $past(rxin_data_i)) else $error("rx byte not passed");
endmodule : avbpt_port

// ---- bench/avbpt_host_model.sv ----
// Host stream model: transmit byte source and receive byte sink
`timescale 1ns/1ps
module avbpt_host_model
  import avbpt_pkg::*;
(
  // Clock and device answers
  input wire logic mclk_i,
  input wire logic tx_ready_i,
  input wire logic txout_valid_i,
  input wire logic rx_valid_i,
  // Transmit stream into the device
  output logic tx_valid_o,
  output logic tx_last_o,
  output logic [BYTE_W-1:0] tx_data_o,
  output logic tx_user_o,
  // Bytes taken from the receive stream
  output int rx_count_o
);
  initial begin
    tx_valid_o = 1'b0;
    tx_last_o = 1'b0;
    tx_data_o = 8'h00;
    tx_user_o = 1'b0;
    rx_count_o = 0;
  end
  // No ready on receive, so every valid cycle must be taken
  always @(posedge mclk_i) begin
    if (rx_valid_i === 1'b1) rx_count_o <= rx_count_o + 1;
  end
  // Holds the byte until the device shows it was taken
  task automatic send(input logic [BYTE_W-1:0] d, input logic l);
    int n;
    @(negedge mclk_i);
    tx_valid_o = 1'b1;
    tx_data_o = d;
    tx_last_o = l;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (!(txout_valid_i === 1'b1 && tx_ready_i === 1'b1) && n < 20);
    tx_valid_o = 1'b0;
    // Released bus must not look like the last byte
    tx_data_o = ~d;
  endtask : send
endmodule : avbpt_host_model

// ---- bench/avbpt_port_bench.sv ----
// Self-checking bench for the time and stream port
`timescale 1ns/1ps
module avbpt_port_bench;
  import avbpt_pkg::*;
  logic mclk_i = 0, srst_i = 1, tx_rst_n_i = 0, rx_rst_n_i = 0;
  logic tx_valid_i, tx_last_i, tx_user_i, tx_ready_o, tx_clk_o, rx_clk_o;
  logic [BYTE_W-1:0] tx_data_i, rxin_data_i = 8'h00, rx_data_o, txout_data_o;
  logic rxin_valid_i = 0, rxin_last_i = 0, rxin_bad_i = 0, rxin_ptp_i = 0, txout_ptp_sent_i = 0;
  logic rx_valid_o, rx_last_o, rx_user_o, txout_valid_o, txout_last_o;
  logic isochronous_cycle_clock_o, ptp_timer_irq_o, ptp_tx_irq_o, ptp_rx_irq_o;
  logic [NS_W-1:0] rtc_ns_o, ns0;
  logic [SEC_W-1:0] rtc_sec_o;
  int fail_count = 0, comparisons = 0, cyc = 0, rx_count, n;
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= srst_i ? 0 : cyc + 1;
  avbpt_port avbpt_port_i (.mclk_i, .srst_i, .tx_clk_o, .rx_clk_o, .tx_rst_n_i, .rx_rst_n_i,
    .tx_valid_i, .tx_ready_o, .tx_last_i, .tx_data_i, .tx_user_i, .rxin_valid_i, .rxin_last_i,
    .rxin_data_i, .rxin_bad_i, .rxin_ptp_i, .rx_valid_o, .rx_last_o, .rx_data_o, .rx_user_o,
    .txout_valid_o, .txout_data_o, .txout_last_o, .txout_ptp_sent_i, .rtc_ns_o, .rtc_sec_o,
    .isochronous_cycle_clock_o, .ptp_timer_irq_o, .ptp_tx_irq_o, .ptp_rx_irq_o);
  avbpt_host_model avbpt_host_model_i (.mclk_i(mclk_i), .tx_ready_i(tx_ready_o),
    .txout_valid_i(txout_valid_o), .rx_valid_i(rx_valid_o), .tx_valid_o(tx_valid_i),
    .tx_last_o(tx_last_i), .tx_data_o(tx_data_i), .tx_user_o(tx_user_i), .rx_count_o(rx_count));
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic tx_test();
    avbpt_host_model_i.send(8'hA5, 1'b0);
    check("tx data", {txout_valid_o, txout_data_o, txout_last_o}, {1'b1, 8'hA5, 1'b0});
    check("tx clocks low on take", {tx_clk_o, rx_clk_o, tx_ready_o}, 3'b001);
    avbpt_host_model_i.send(8'h3C, 1'b1);
    check("tx last", {txout_valid_o, txout_data_o, txout_last_o}, {1'b1, 8'h3C, 1'b1});
    @(negedge mclk_i);
    check("tx clocks rise", {tx_clk_o, rx_clk_o, txout_valid_o}, 3'b110);
  endtask : tx_test
  task automatic rx_test(input logic bad);
    n = rx_count;
    rxin_valid_i = 1'b1;
    rxin_last_i = 1'b1;
    rxin_data_i = 8'h5A;
    rxin_bad_i = bad;
    rxin_ptp_i = 1'b1;
    @(negedge mclk_i);
    rxin_valid_i = 1'b0;
    rxin_ptp_i = 1'b0;
    rxin_data_i = 8'hA5;
    check("rx byte", {rx_valid_o, rx_last_o, rx_data_o}, {2'b11, 8'h5A});
    check("rx user", rx_user_o, bad);
    @(negedge mclk_i);
    check("rx irq", ptp_rx_irq_o, 1'b1);
    check("rx taken", rx_count - n, 1);
    @(negedge mclk_i);
    check("rx irq end", ptp_rx_irq_o, 1'b0);
    repeat (4) @(negedge mclk_i);
  endtask : rx_test
  task automatic tx_ptp_test();
    txout_ptp_sent_i = 1'b1;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (ptp_tx_irq_o !== 1'b1 && n < 10);
    check("tx irq delay", n, 3);
    @(negedge mclk_i);
    check("tx irq end", ptp_tx_irq_o, 1'b0);
    txout_ptp_sent_i = 1'b0;
  endtask : tx_ptp_test
  task automatic time_test();
    ns0 = rtc_ns_o;
    repeat (10) @(negedge mclk_i);
    check("ns step", rtc_ns_o, ns0 + 32'h0000_03E8);
    check("seconds", rtc_sec_o, 48'h0000_0000_0000);
    ns0[0] = isochronous_cycle_clock_o;
    n = 0;
    while (isochronous_cycle_clock_o === ns0[0] && n < 700) @(negedge mclk_i) n++;
    n = 0;
    while (isochronous_cycle_clock_o !== ns0[0] && n < 700) @(negedge mclk_i) n++;
    check("iso half period", n, ISO_HALF_CYCLES);
  endtask : time_test
  initial begin
    #(150_000 * 100);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(negedge mclk_i);
    check("idle outputs", {rx_valid_o, txout_valid_o, ptp_rx_irq_o, ptp_tx_irq_o}, 4'h0);
    srst_i = 1'b0;
    tx_rst_n_i = 1'b1;
    rx_rst_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    tx_test();
    rx_test(1'b1);
    rx_test(1'b0);
    tx_ptp_test();
    time_test();
    n = 0;
    while (ptp_timer_irq_o !== 1'b1 && n < 110_000) @(negedge mclk_i) n++;
    check("timer tick", cyc, TICK_CYCLES);
    @(negedge mclk_i);
    check("timer pulse end", ptp_timer_irq_o, 1'b0);
    wrap_up();
  end
endmodule : avbpt_port_bench
